/* File: dcp_consts.vh */
// Constants for the packet-channel decoder: slot positions, header layout,
// register map and command encodings.
// Assumes inclusion by dcp_packet_decoder.v and by the testbench; definitions only.
`ifndef DCP_CONSTS_VH
`define DCP_CONSTS_VH

// Bit slots within one packet interval (two per link clock cycle)
`define DCP_SLOT_W        3
`define DCP_LAST_SLOT     3'h7
`define DCP_START_SLOT    0
`define DCP_RBEGIN_SLOT   1
`define DCP_WAKE_SLOT     2
`define DCP_REND_SLOT     3
`define DCP_WBEGIN_SLOT   5
`define DCP_WEND_SLOT     7

// Header layout inside the 72 data-wire bits of the header interval
`define DCP_HDR_W         53
`define DCP_ADDR_LSB      0
`define DCP_ADDR_MSB      32
`define DCP_OP_LSB        33
`define DCP_OP_MSB        38
`define DCP_OPEN_BIT      39
`define DCP_CLOSE_BIT     40
`define DCP_REGISTER_SPACE_BIT_BIT    41
`define DCP_SKIP_LSB      42
`define DCP_SKIP_MSB      44
`define DCP_MASK_LSB      45
`define DCP_MASK_MSB      52

// Request address split (address bit An sits at field index n-3)
`define DCP_COL_LSB       0
`define DCP_COL_MSB       7
`define DCP_ROW_LSB       8
`define DCP_ROW_S_MSB     16
`define DCP_ROW_L_MSB     17
`define DCP_BANK_S_BIT    17
`define DCP_BANK_L_LSB    18
`define DCP_BANK_L_MSB    19
`define DCP_DEV_S_LSB     18
`define DCP_DEV_L_LSB     20

// Command field encodings
`define DCP_OP_MEM_RD     2'h0
`define DCP_OP_MEM_WR     2'h1
`define DCP_OP_REG_RD     4'h6
`define DCP_OP_REG_WR     3'h7
`define DCP_MASK_ALL      8'hff

// Register map (byte addresses)
`define DCP_REG_CTRL      8'h00
`define DCP_REG_STATUS    8'h04
`define DCP_REG_HEADER    8'h08
`define DCP_CTRL_RESET    1'h0

// Transaction states
`define DCP_ST_W          2
`endif

/* File: dcp_packet_decoder.v */
// Packet layer of a packet-channel DRAM device: finds packet intervals,
// decodes command headers, markers, column and data packets, tracks banks.
// Assumes the channel wires and link clock come from another clock domain
// and are sampled here; registers are reached over classic Wishbone.
//
// Summary of operation
// - Each wire carries eight bits per interval, one per link clock edge.
// - Address splits into column, row, bank and device fields per part size.
// - Command bit 0 read/write, bit 2 byte mask, bit 3 broadcast, 5..4 bitmask.
// - Bit 1 picks register space; encodings 00 read, 01 write, 0110, x111.
// - Open-row bit activates, or precharges then activates, the bank first.
// - Self-close bit precharges the bank after the last data access.
// - Header start bit is one and defines packet interval boundaries.
// - Data, column and marker packets align to those interval boundaries.
// - Nonzero skip count ignores that many earlier begin and end markers.
// - Memory writes apply the header byte mask to the first word only.
// - Data packets carry 72 bits on nine wires, ninth wire extra bits.
// - First column from header, later columns from column-wire packets.
// - Column packets keep a fixed offset from their data packets.
// - Read markers are single ones in odd slots bracketing read data.
// - Single-word read markers coincide; end overlays anything, begin not headers.
// - Write markers are single odd-slot ones and never coincide.
// - Write begin may overlay a header; write end may not.
// - Wake leaves suspend; finished transaction returns to suspend unless a header is pending.
// - Always-awake set keeps the device enabled without wake packets.
// - Wake may overlay read markers and still decodes correctly.
// - Per-bank open flag tells activate from precharge-then-activate.
//
// The register addresses and the Wishbone slave port were left to the implementer.
`include "dcp_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module dcp_packet_decoder #(
	parameter LARGE_PART = 0,
	parameter NUM_BANKS  = 4
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        link_clk_i,
	input  wire        command_wire_i,
	input  wire        column_wire_i,
	input  wire [8:0]  data_wires_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         activate_o,
	output reg         pre_activate_o,
	output reg         precharge_o,
	output reg  [1:0]  precharge_bank_o,
	output reg         wr_valid_o,
	output reg         rd_valid_o,
	output reg  [7:0]  word_col_o,
	output reg  [71:0] wr_data_o,
	output reg  [7:0]  wr_mask_o,
	output wire [1:0]  bank_o,
	output wire [9:0]  row_o,
	output wire [14:0] dev_o,
	output wire        reg_space_o,
	output wire        broadcast_o,
	output wire        byte_mask_en_o,
	output wire [1:0]  bit_mask_o,
	output wire        awake_o
);

	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_DATA = 2'h2;

	// Synchronisers: stage 1 feeds stage 2 only
	reg        lk_s1_q, lk_s2_q, lk_s3_q;
	reg        cw_s1_q, cw_s2_q, aw_s1_q, aw_s2_q;
	reg  [8:0] dq_s1_q, dq_s2_q;

	always @(posedge clk_i) begin
		if (rst_i) begin
			lk_s1_q <= 1'b0;
			lk_s2_q <= 1'b0;
			lk_s3_q <= 1'b0;
			cw_s1_q <= 1'b0;
			cw_s2_q <= 1'b0;
			aw_s1_q <= 1'b0;
			aw_s2_q <= 1'b0;
			dq_s1_q <= 9'h000;
			dq_s2_q <= 9'h000;
		end else begin
			lk_s1_q <= link_clk_i;
			lk_s2_q <= lk_s1_q;
			lk_s3_q <= lk_s2_q;
			cw_s1_q <= command_wire_i;
			cw_s2_q <= cw_s1_q;
			aw_s1_q <= column_wire_i;
			aw_s2_q <= aw_s1_q;
			dq_s1_q <= data_wires_i;
			dq_s2_q <= dq_s1_q;
		end
	end

	// Either link clock edge carries one bit per wire
	wire link_edge = lk_s2_q ^ lk_s3_q;

	// Interval assembly state
	reg        aligned_q;
	reg  [2:0] slot_q;
	reg  [7:0] cmd_q, col_q;
	reg  [71:0] dat_q;
	reg  [7:0] cmd_nx, col_nx;
	reg  [71:0] dat_nx;
	integer    w;

	// Current bit dropped into its slot; data bit index is wire*8+slot
	always @* begin
		cmd_nx = cmd_q;
		col_nx = col_q;
		dat_nx = dat_q;
		cmd_nx[slot_q] = cw_s2_q;
		col_nx[slot_q] = aw_s2_q;
		for (w = 0; w < 9; w = w + 1) begin
			dat_nx[w*8 + slot_q] = dq_s2_q[w];
		end
	end

	// Before alignment, the first one on the command wire is a start bit
	wire take_bit = link_edge & (aligned_q | cw_s2_q);
	wire pkt_done = link_edge & aligned_q & (slot_q == `DCP_LAST_SLOT);

	always @(posedge clk_i) begin
		if (rst_i) begin
			aligned_q <= 1'b0;
			slot_q    <= 3'h0;
			cmd_q     <= 8'h00;
			col_q     <= 8'h00;
			dat_q     <= 72'h0;
		end else if (take_bit) begin
			aligned_q <= 1'b1;
			slot_q    <= slot_q + 3'h1;
			if (pkt_done) begin
				cmd_q <= 8'h00;
				col_q <= 8'h00;
				dat_q <= 72'h0;
			end else begin
				cmd_q <= cmd_nx;
				col_q <= col_nx;
				dat_q <= dat_nx;
			end
		end
	end

	// Command-wire packet classes; markers OR together when overlaid
	wire is_hdr  = cmd_nx[`DCP_START_SLOT];
	wire is_wake = cmd_nx[`DCP_WAKE_SLOT];
	wire m_rb    = cmd_nx[`DCP_RBEGIN_SLOT];
	wire m_re    = cmd_nx[`DCP_REND_SLOT];
	wire m_wb    = cmd_nx[`DCP_WBEGIN_SLOT];
	wire m_we    = cmd_nx[`DCP_WEND_SLOT];
	wire [2:0] mk_cnt = {2'b00, m_rb} + {2'b00, m_re} + {2'b00, m_wb} + {2'b00, m_we};

	// Skip counter decrement that stops at zero
	function [2:0] sat_sub;
		input [2:0] a;
		input [2:0] b;
		begin
			sat_sub = (a > b) ? (a - b) : 3'h0;
		end
	endfunction

	// Software control: always-awake flag
	reg always_awake_q;
	reg awake_q;
	wire awake_eff = awake_q | always_awake_q;
	wire hdr_ok    = pkt_done & is_hdr & awake_eff;

	// Transaction bookkeeping: one current and one pending header
	reg [1:0]  state_q;
	reg [52:0] cur_hdr_q, pend_hdr_q, last_hdr_q;
	reg        pend_valid_q;
	reg [2:0]  cur_skip_q, pend_skip_q;
	reg        first_q, last_q, start_q;
	reg [7:0]  col_prev_q;
	reg [NUM_BANKS-1:0] bank_open_q;

	wire [5:0]  cur_op   = cur_hdr_q[`DCP_OP_MSB:`DCP_OP_LSB];
	wire [32:0] cur_addr = cur_hdr_q[`DCP_ADDR_MSB:`DCP_ADDR_LSB];
	wire        cur_wr   = cur_op[0];
	wire        cur_mwr  = (cur_op[1:0] == `DCP_OP_MEM_WR);
	wire        begin_hit = cur_wr ? m_wb : m_rb;
	wire [52:0] hdr_in   = dat_nx[`DCP_HDR_W-1:0];
	wire [2:0]  hdr_skip = hdr_in[`DCP_SKIP_MSB:`DCP_SKIP_LSB];

	// Address split chosen by the static part-size parameter
	generate
		if (LARGE_PART != 0) begin : g_large
			assign row_o  = cur_addr[`DCP_ROW_L_MSB:`DCP_ROW_LSB];
			assign bank_o = cur_addr[`DCP_BANK_L_MSB:`DCP_BANK_L_LSB];
			assign dev_o  = {2'b00, cur_addr[`DCP_ADDR_MSB:`DCP_DEV_L_LSB]};
		end else begin : g_small
			assign row_o  = {1'b0, cur_addr[`DCP_ROW_S_MSB:`DCP_ROW_LSB]};
			assign bank_o = {1'b0, cur_addr[`DCP_BANK_S_BIT]};
			assign dev_o  = cur_addr[`DCP_ADDR_MSB:`DCP_DEV_S_LSB];
		end
	endgenerate

	// Command option decode
	assign reg_space_o    = cur_op[1] | cur_hdr_q[`DCP_REGISTER_SPACE_BIT_BIT];
	assign broadcast_o    = cur_op[3];
	assign byte_mask_en_o = cur_op[2];
	assign bit_mask_o     = cur_op[5:4];
	assign awake_o        = awake_eff;

	wire [7:0] hdr_col  = cur_addr[`DCP_COL_MSB:`DCP_COL_LSB];
	wire       finishing = pkt_done & (state_q == ST_DATA) & (cur_wr ? m_we : last_q);
	wire       reg_rd    = (cur_op[3:0] == `DCP_OP_REG_RD);
	wire       reg_wr    = (cur_op[2:0] == `DCP_OP_REG_WR);

	// Transaction sequencing, bank actions and data word emission
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_q          <= ST_IDLE;
			cur_hdr_q        <= 53'h0;
			pend_hdr_q       <= 53'h0;
			last_hdr_q       <= 53'h0;
			pend_valid_q     <= 1'b0;
			cur_skip_q       <= 3'h0;
			pend_skip_q      <= 3'h0;
			first_q          <= 1'b0;
			last_q           <= 1'b0;
			start_q          <= 1'b0;
			col_prev_q       <= 8'h00;
			bank_open_q      <= {NUM_BANKS{1'b0}};
			activate_o       <= 1'b0;
			pre_activate_o   <= 1'b0;
			precharge_o      <= 1'b0;
			precharge_bank_o <= 2'h0;
			wr_valid_o       <= 1'b0;
			rd_valid_o       <= 1'b0;
			word_col_o       <= 8'h00;
			wr_data_o        <= 72'h0;
			wr_mask_o        <= 8'h00;
		end else begin
			activate_o     <= 1'b0;
			pre_activate_o <= 1'b0;
			precharge_o    <= 1'b0;
			wr_valid_o     <= 1'b0;
			rd_valid_o     <= 1'b0;
			start_q        <= 1'b0;
			// Bank flag decides which open form the header meant
			if (start_q && cur_hdr_q[`DCP_OPEN_BIT]) begin
				if (bank_open_q[bank_o])
					pre_activate_o <= 1'b1;
				else
					activate_o <= 1'b1;
				bank_open_q[bank_o] <= 1'b1;
			end
			if (pkt_done) begin
				col_prev_q <= col_nx;
				if (hdr_ok)
					last_hdr_q <= hdr_in;
				if (pend_valid_q)
					pend_skip_q <= sat_sub(pend_skip_q, mk_cnt);
				case (state_q)
					ST_IDLE: begin
						if (hdr_ok) begin
							cur_hdr_q  <= hdr_in;
							cur_skip_q <= hdr_skip;
							start_q    <= 1'b1;
							// A write begin laid over its own header starts the data at once
							if (hdr_skip == 3'h0 && hdr_in[`DCP_OP_LSB] && m_wb) begin
								state_q <= ST_DATA;
								first_q <= 1'b1;
								last_q  <= 1'b0;
							end else begin
								state_q <= ST_WAIT;
							end
						end
					end
					ST_WAIT: begin
						if (hdr_ok) begin
							pend_hdr_q   <= hdr_in;
							pend_skip_q  <= hdr_skip;
							pend_valid_q <= 1'b1;
						end
						// Earlier transactions' markers are passed over first
						if (cur_skip_q != 3'h0) begin
							cur_skip_q <= sat_sub(cur_skip_q, mk_cnt);
						end else if (begin_hit) begin
							state_q <= ST_DATA;
							first_q <= 1'b1;
							last_q  <= ~cur_wr & m_re;
						end
					end
					ST_DATA: begin
						if (hdr_ok) begin
							pend_hdr_q   <= hdr_in;
							pend_skip_q  <= hdr_skip;
							pend_valid_q <= 1'b1;
						end
						// Data word lands one interval after its begin marker
						first_q    <= 1'b0;
						word_col_o <= first_q ? hdr_col : col_prev_q;
						wr_data_o  <= dat_nx;
						if (cur_wr) begin
							wr_valid_o <= 1'b1;
							wr_mask_o  <= (first_q & cur_mwr) ?
								cur_hdr_q[`DCP_MASK_MSB:`DCP_MASK_LSB] : `DCP_MASK_ALL;
						end else begin
							rd_valid_o <= 1'b1;
							wr_mask_o  <= `DCP_MASK_ALL;
							if (m_re)
								last_q <= 1'b1;
						end
						if (finishing) begin
							if (cur_hdr_q[`DCP_CLOSE_BIT]) begin
								precharge_o      <= 1'b1;
								precharge_bank_o <= bank_o;
								bank_open_q[bank_o] <= 1'b0;
							end
							last_q <= 1'b0;
							if (pend_valid_q) begin
								cur_hdr_q    <= pend_hdr_q;
								cur_skip_q   <= sat_sub(pend_skip_q, mk_cnt);
								pend_valid_q <= 1'b0;
								start_q      <= 1'b1;
								state_q      <= ST_WAIT;
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// Suspend control; a wake in the finishing interval wins over the drop
	always @(posedge clk_i) begin
		if (rst_i) begin
			awake_q <= 1'b0;
		end else begin
			if (finishing && !pend_valid_q)
				awake_q <= 1'b0;
			if (pkt_done && is_wake)
				awake_q <= 1'b1;
		end
	end

	// Wishbone slave: ack one cycle after the strobe, writes commit with ack
	wire wb_req = wb_cyc_i & wb_stb_i;

	// Bank flags padded to the four status positions; unused banks read zero
	wire [3:0] bank_flags_w;
	genvar gb;
	generate
		for (gb = 0; gb < 4; gb = gb + 1) begin : g_bank_flag
			if (gb < NUM_BANKS) begin : g_used
				assign bank_flags_w[gb] = bank_open_q[gb];
			end else begin : g_unused
				assign bank_flags_w[gb] = 1'b0;
			end
		end
	endgenerate

	wire [31:0] status_w = {16'h0000, 1'b0, reg_wr, reg_rd, 1'b0, cur_skip_q,
		bank_flags_w, pend_valid_q, state_q, aligned_q, awake_eff};

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o       <= 1'b0;
			wb_dat_o       <= 32'h0;
			always_awake_q <= `DCP_CTRL_RESET;
		end else begin
			wb_ack_o <= wb_req & ~wb_ack_o;
			if (wb_req && !wb_ack_o) begin
				case (wb_adr_i)
					`DCP_REG_CTRL:   wb_dat_o <= {31'h0, always_awake_q};
					`DCP_REG_STATUS: wb_dat_o <= status_w;
					`DCP_REG_HEADER: wb_dat_o <= last_hdr_q[31:0];
					default:         wb_dat_o <= 32'h0;
				endcase
			end
			if (wb_req && wb_ack_o && wb_we_i && wb_sel_i[0] &&
				wb_adr_i == `DCP_REG_CTRL)
				always_awake_q <= wb_dat_i[0];
		end
	end

endmodule

`default_nettype wire

/* File: dcp_checker.sv */
// Checker for the packet decoder: bus handshake, decode and pulse relations.
// Assumes it is bound to dcp_packet_decoder and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dcp_checker #(
	parameter LARGE_PART = 0
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        activate_o,
	input wire logic        pre_activate_o,
	input wire logic        wr_valid_o,
	input wire logic        rd_valid_o,
	input wire logic [1:0]  bank_o,
	input wire logic [9:0]  row_o,
	input wire logic        awake_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Bus answers a fresh request in one cycle, for one cycle only
	ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h08
		|-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	// Read data moves only together with an answer
	rdata_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o) else $error("data moved");
	// Open bank flag picks at most one of the two row operations
	act_exclusive_a: assert property (!(activate_o && pre_activate_o))
		else $error("both row ops");
	dir_exclusive_a: assert property (!(wr_valid_o && rd_valid_o))
		else $error("read and write together");
	act_awake_a: assert property (activate_o |-> awake_o)
		else $error("row op while suspended");
	awake_set_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h00
		&& wb_sel_i[0] && wb_dat_i[0] |=> awake_o) else $error("not awake");
	small_split_a: assert property (LARGE_PART != 0
		|| (bank_o[1] == 1'b0 && row_o[9] == 1'b0)) else $error("split width");
endmodule
bind dcp_packet_decoder dcp_checker #(.LARGE_PART(LARGE_PART)) i_dcp_checker (.clk_i,
	.rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
	.wb_ack_o, .activate_o, .pre_activate_o, .wr_valid_o, .rd_valid_o, .bank_o, .row_o,
	.awake_o);
`default_nettype wire

/* File: dcp_ctl_model.sv */
// Memory controller model: sends whole packet intervals on the channel.
// Assumes the decoder finds its bit slots from the link clock edges.
`timescale 1ns/1ps
`default_nettype none
module dcp_ctl_model (
	output var logic       link_clk_o,
	output var logic       cmd_o,
	output var logic       col_o,
	output var logic [8:0] dat_o
);
	// Clock idles low between intervals
	initial begin
		link_clk_o = 1'b0;
		cmd_o = 1'b0;
		col_o = 1'b0;
		dat_o = 9'h0;
	end
	// One bit per wire on every link edge, eight edges an interval
	task automatic send(input logic [7:0] cmd, input logic [7:0] col, input logic [71:0] d);
		int s;
		int w;
		for (s = 0; s < 8; s++) begin
			cmd_o = cmd[s];
			col_o = col[s];
			for (w = 0; w < 9; w++) dat_o[w] = d[w * 8 + s];
			#16 link_clk_o = ~link_clk_o;
			#16;
		end
		// Released wires show stale inverted values so nothing reads them by luck
		cmd_o = ~cmd_o;
		col_o = ~col_o;
		dat_o = ~dat_o;
	endtask
	// Header: start bit in slot 0, reserved bits low
	task automatic header(input logic [52:0] h, input logic [7:0] extra);
		send(extra | 8'h01, 8'h00, {19'h0, h});
	endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Testbench: register bus and channel traffic, decoded outputs compared.
// Assumes the controller model drives the channel wires.
`timescale 1ns/1ps
`default_nettype none
`include "dcp_consts.vh"
module tb_top;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, q;
	logic [1:0]  pbank;
	wire  [31:0] wb_dat_o;
	wire         link_clk_i, command_wire_i, column_wire_i, wb_ack_o, precharge_o;
	wire         activate_o, pre_activate_o, wr_valid_o, rd_valid_o, awake_o;
	wire         reg_space_o, broadcast_o, byte_mask_en_o;
	wire  [8:0]  data_wires_i;
	wire  [1:0]  precharge_bank_o, bank_o, bit_mask_o;
	wire  [7:0]  word_col_o, wr_mask_o;
	wire  [71:0] wr_data_o;
	wire  [9:0]  row_o;
	wire  [14:0] dev_o;
	int          failures = 0, tests_run = 0, nact = 0, npre = 0, npch = 0;
	logic [87:0] evq[$];
	localparam logic [32:0] A1 = {15'h0055, 1'b1, 9'h0a5, 8'h3c};
	localparam logic [32:0] A2 = {15'h0000, 1'b0, 9'h003, 8'h11};
	localparam logic [32:0] A3 = {15'h0000, 1'b0, 9'h003, 8'h22};
	localparam logic [71:0] D0 = 72'hab_0123456789abcdef;
	localparam logic [71:0] D1 = 72'h54_fedcba9876543210;
	dcp_packet_decoder i_dcp_packet_decoder (.clk_i, .rst_i, .link_clk_i, .command_wire_i,
		.column_wire_i, .data_wires_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .activate_o, .pre_activate_o, .precharge_o,
		.precharge_bank_o, .wr_valid_o, .rd_valid_o, .word_col_o, .wr_data_o, .wr_mask_o,
		.bank_o, .row_o, .dev_o, .reg_space_o, .broadcast_o, .byte_mask_en_o, .bit_mask_o,
		.awake_o);
	dcp_ctl_model i_dcp_ctl_model (.link_clk_o(link_clk_i), .cmd_o(command_wire_i),
		.col_o(column_wire_i), .dat_o(data_wires_i));
	// 200 MHz system clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// Log each word and bank operation; pulses last one cycle, so sample every edge
	always @(posedge clk_i) begin
		if (wr_valid_o === 1'b1) evq.push_back({wr_mask_o, word_col_o, wr_data_o});
		if (rd_valid_o === 1'b1) evq.push_back({8'h00, word_col_o, 72'h0});
		if (activate_o === 1'b1) nact++;
		if (pre_activate_o === 1'b1) npre++;
		if (precharge_o === 1'b1) begin
			npch++;
			pbank = precharge_bank_o;
		end
	end
	task automatic chk(input string nm, input logic [87:0] s, input logic [87:0] e);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Classic single cycle; request held until ack is sampled high at a rising edge
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			failures++;
			finish_test();
		end
		// Read data taken at the edge that sees ack, then the request is released
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic wait_q(input int n);
		int i;
		for (i = 0; i < 80 && evq.size() < n; i++) @(posedge clk_i);
		if (evq.size() < n) begin
			failures++;
			finish_test();
		end
		repeat (4) @(posedge clk_i);
	endtask
	function automatic logic [52:0] hdr(input logic [5:0] op, input logic o, input logic c,
		input logic [2:0] sk, input logic [7:0] m, input logic [32:0] a);
		return {m, sk, op[1], c, o, op, a};
	endfunction
	initial begin
		rst_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		wb_sel_i = 4'hf;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		wb(1'b0, `DCP_REG_CTRL, 32'h0);
		chk("ctrl", q, 32'h0);
		wb(1'b1, 8'h0c, 32'hffffffff);
		wb(1'b0, 8'h0c, 32'h0);
		chk("unmapped", q, 32'h0);
		$display("test registers done");
		// Suspended: first header only aligns, then wake lets the next one in
		i_dcp_ctl_model.header(hdr(6'h3d, 1'b1, 1'b1, 3'h0, 8'h0f, A1), 8'h00);
		repeat (10) @(posedge clk_i);
		chk("act", nact, 0);
		i_dcp_ctl_model.send(8'h04, 8'h00, 72'h0);
		repeat (10) @(posedge clk_i);
		chk("woken", awake_o, 1'b1);
		i_dcp_ctl_model.header(hdr(6'h3d, 1'b1, 1'b1, 3'h0, 8'h0f, A1), 8'h00);
		repeat (10) @(posedge clk_i);
		chk("act", nact, 1);
		chk("split", {dev_o, row_o, bank_o}, {15'h0055, 10'h0a5, 2'h1});
		chk("opts", {reg_space_o, broadcast_o, byte_mask_en_o, bit_mask_o}, 5'h0f);
		i_dcp_ctl_model.send(8'h20, 8'h00, 72'h0);
		i_dcp_ctl_model.send(8'h00, 8'h41, D0);
		i_dcp_ctl_model.send(8'h80, 8'h00, D1);
		wait_q(2);
		chk("word0", evq.pop_front(), {8'h0f, 8'h3c, D0});
		chk("word1", evq.pop_front(), {8'hff, 8'h41, D1});
		chk("close", {npch, pbank}, {32'h1, 2'h1});
		chk("asleep", awake_o, 1'b0);
		wb(1'b0, `DCP_REG_HEADER, 32'h0);
		chk("header", q, A1[31:0]);
		$display("test write done");
		wb(1'b1, `DCP_REG_CTRL, 32'h1);
		wb(1'b0, `DCP_REG_CTRL, 32'h0);
		chk("ctrl", q, 32'h1);
		i_dcp_ctl_model.header(hdr(6'h00, 1'b1, 1'b0, 3'h0, 8'hff, A2), 8'h00);
		i_dcp_ctl_model.send(8'h0a, 8'h00, 72'h0);
		i_dcp_ctl_model.send(8'h00, 8'h00, 72'h0);
		wait_q(1);
		chk("read0", evq.pop_front(), {16'h0011, 72'h0});
		chk("act", nact, 2);
		i_dcp_ctl_model.header(hdr(6'h00, 1'b1, 1'b0, 3'h1, 8'hff, A3), 8'h00);
		i_dcp_ctl_model.send(8'h02, 8'h00, 72'h0);
		i_dcp_ctl_model.send(8'h0e, 8'h00, 72'h0);
		i_dcp_ctl_model.send(8'h00, 8'h00, 72'h0);
		wait_q(1);
		chk("read1", evq.pop_front(), {16'h0022, 72'h0});
		chk("extra", evq.size(), 0);
		chk("reopen", npre, 1);
		chk("awake", awake_o, 1'b1);
		$display("test read done");
		// Write begin overlaid on its header, single word closed by the end marker
		i_dcp_ctl_model.header(hdr(6'h01, 1'b0, 1'b0, 3'h0, 8'hf0, A2), 8'h20);
		i_dcp_ctl_model.send(8'h80, 8'h00, D0);
		wait_q(1);
		chk("overlay", evq.pop_front(), {8'hf0, 8'h11, D0});
		wb(1'b0, `DCP_REG_STATUS, 32'h0);
		chk("status", q, 32'h23);
		$display("test overlay done");
		finish_test();
	end
endmodule
`default_nettype wire
